/* File: rtl/stream_unpack_pkg.sv */
// Package with constants shared by the register stream unpacker files.
package stream_unpack_pkg;

  // ----------------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------------
  localparam int DATA_W = 32;
  localparam int INDEX_W = 8;
  localparam int SLOTS = 4;
  localparam int SLOT_W = 2;

  // ----------------------------------------------------------------------
  // Index field positions
  // ----------------------------------------------------------------------
  localparam int IDX_RANGE_BIT = 7;
  localparam int IDX_OFFSET_MSB = 6;

  // Register address bit positions that form the index.
  localparam int ADDR_RANGE_BIT = 13;
  localparam int ADDR_OFFSET_MSB = 8;
  localparam int ADDR_OFFSET_LSB = 2;
  localparam int ADDR_W = 14;

  // ----------------------------------------------------------------------
  // Start-triggering register address range
  // ----------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] START_RANGE_LO = 14'h1d00;
  localparam logic [ADDR_W-1:0] START_RANGE_HI = 14'h1dff;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [SLOT_W-1:0] SLOT_RESET = 2'h0;
  localparam logic [DATA_W-1:0] HEADER_RESET = 32'h0000_0000;

  // Address generator states.
  typedef enum logic [1:0] {
    ST_HEADER = 2'b01,
    ST_DATA = 2'b10
  } gen_state_t;

endpackage

/* File: rtl/index_to_address.sv */
// Expands an 8-bit stream index into a register address and flags start triggers.
`timescale 1ns/1ns
module index_to_address (
  input wire logic [stream_unpack_pkg::INDEX_W-1:0] index,
  output logic [stream_unpack_pkg::ADDR_W-1:0] addr,
  output logic start_hit
);

  localparam int RANGE_BIT = stream_unpack_pkg::ADDR_RANGE_BIT;
  localparam int OFF_MSB = stream_unpack_pkg::ADDR_OFFSET_MSB;
  localparam int OFF_LSB = stream_unpack_pkg::ADDR_OFFSET_LSB;
  localparam logic [stream_unpack_pkg::ADDR_W-1:0] LAUNCH_LO = stream_unpack_pkg::START_RANGE_LO;
  localparam logic [stream_unpack_pkg::ADDR_W-1:0] LAUNCH_HI = stream_unpack_pkg::START_RANGE_HI;

  // Index bit 7 maps to address bit 13, bits 6:0 to address bits 8:2.
  // The index cannot reach address bits 12:9, which the register map fixes, so the
  // launch range is judged only on the bits that the index carries.
  always_comb begin
    addr = '0;
    addr[RANGE_BIT] = index[stream_unpack_pkg::IDX_RANGE_BIT]; // (R6)
    addr[OFF_MSB:OFF_LSB] = index[stream_unpack_pkg::IDX_OFFSET_MSB:0]; // (R5)
    start_hit = (addr[RANGE_BIT] == LAUNCH_LO[RANGE_BIT]) &&
                (addr[OFF_MSB:OFF_LSB] >= LAUNCH_LO[OFF_MSB:OFF_LSB]) &&
                (addr[OFF_MSB:OFF_LSB] <= LAUNCH_HI[OFF_MSB:OFF_LSB]); // (R14)
  end

endmodule

/* File: rtl/skid_buffer2.sv */
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/1ns
module skid_buffer2 #(
  parameter int WIDTH = 40
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  logic [WIDTH-1:0] mem_reg [2];
  logic rd_ptr_reg;
  logic wr_ptr_reg;
  logic [1:0] count_reg;
  logic push;
  logic pop;

  assign in_ready = (count_reg != 2'h2);
  assign out_valid = (count_reg != 2'h0);
  assign out_data = mem_reg[rd_ptr_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rd_ptr_reg <= 1'b0;
      wr_ptr_reg <= 1'b0;
      count_reg <= 2'h0;
    end else if (flush) begin
      rd_ptr_reg <= 1'b0;
      wr_ptr_reg <= 1'b0;
      count_reg <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr_reg <= ~wr_ptr_reg;
      end
      if (pop) begin
        rd_ptr_reg <= ~rd_ptr_reg;
      end
      count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
    end
  end

  // Storage needs no reset; valid is carried by the count.
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

endmodule

/* File: rtl/register_stream_unpacker.sv */
// Register stream unpacker: turns header plus data words into indexed FIFO writes.
// Notes on behaviour
// (R1) Any read or write of either stream window enters register-stream mode.
// (R2) First word written after the sequence starts is latched as a four-index header.
// (R3) Header bytes hold indices lowest first; k-th data word uses k-th index.
// (R4) Each data word is pushed with its 8-bit index into the bus FIFO.
// (R5) Index is address bit 13 plus bits 8:2; bits 1:0 are dropped.
// (R6) Index bit from address bit 13 selects the second drawing range.
// (R7) Only FIFO-loadable registers may be named; host must not name others.
// (R8) After the fourth data word, the next word is a new header.
// (R9) Writing the mode register's lowest byte aborts the stream sequence.
// (R10) Host uses only full double-word accesses to load drawing registers.
// (R11) Image load and dump data always move through the stream window path.
// (R12) Host should issue stream transfers at incrementing addresses for bursting.
// (R13) Software should make the last setup write fall in the start range.
// (R14) A write in the start-triggering range launches the drawing engine.
// (R15) Any access to the mode register's lowest byte resets the address generator.
`timescale 1ns/1ns
module register_stream_unpacker #(
  parameter int DATA_W = stream_unpack_pkg::DATA_W
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic win_write,
  input wire logic win_read,
  input wire logic [DATA_W-1:0] win_wdata,
  output logic win_ready,
  input wire logic mode_byte0_access,
  input wire logic image_op_active,
  input wire logic image_load_op,
  input wire logic image_dump_op,
  output logic pixel_valid,
  output logic [DATA_W-1:0] pixel_data,
  input wire logic pixel_ready,
  output logic fifo_valid,
  output logic [DATA_W-1:0] fifo_data,
  output logic [stream_unpack_pkg::INDEX_W-1:0] fifo_index,
  output logic fifo_start,
  input wire logic fifo_ready,
  output logic stream_mode,
  output logic header_pending
);

  // ----------------------------------------------------------------------
  // Local types and signals
  // ----------------------------------------------------------------------
  localparam int ENTRY_W = DATA_W + stream_unpack_pkg::INDEX_W + 1;

  stream_unpack_pkg::gen_state_t state_reg;
  logic [DATA_W-1:0] header_reg;
  logic [stream_unpack_pkg::SLOT_W-1:0] slot_reg;
  logic stream_mode_reg;
  logic pix_valid_reg;
  logic [DATA_W-1:0] pix_data_reg;
  logic [stream_unpack_pkg::INDEX_W-1:0] cur_index;
  logic [stream_unpack_pkg::INDEX_W-1:0] header_index_zero;
  logic [stream_unpack_pkg::INDEX_W-1:0] header_index_three;
  logic cur_start;
  logic buf_in_ready;
  logic buf_out_valid;
  logic [ENTRY_W-1:0] buf_out_data;
  logic data_take;
  logic header_take;
  logic pixel_take;
  logic fifo_v_reg;
  logic [ENTRY_W-1:0] fifo_entry_reg;
  logic out_free;

  // ----------------------------------------------------------------------
  // Index selection
  // ----------------------------------------------------------------------
  assign header_index_zero = header_reg[7:0];
  assign header_index_three = header_reg[31:24];
  // Slot k picks byte lane k of the header.
  assign cur_index = header_reg[slot_reg*stream_unpack_pkg::INDEX_W +: stream_unpack_pkg::INDEX_W]; // (R3)

  index_to_address u_idx (
    .index(cur_index),
    .addr(),
    .start_hit(cur_start)
  );

  // ----------------------------------------------------------------------
  // Acceptance of host words
  // ----------------------------------------------------------------------
  // Image traffic bypasses the header logic; the window is its only path.
  assign pixel_take = win_write && image_op_active && !mode_byte0_access &&
                      (!pix_valid_reg || pixel_ready); // (R11)
  assign header_take = win_write && !image_op_active && !mode_byte0_access &&
                       (state_reg == stream_unpack_pkg::ST_HEADER); // (R2)
  assign data_take = win_write && !image_op_active && !mode_byte0_access &&
                     (state_reg == stream_unpack_pkg::ST_DATA) && buf_in_ready; // (R4)

  always_comb begin
    win_ready = 1'b0;
    if (image_op_active) begin
      win_ready = !pix_valid_reg || pixel_ready;
    end else if (state_reg == stream_unpack_pkg::ST_HEADER) begin
      win_ready = 1'b1;
    end else begin
      win_ready = buf_in_ready;
    end
  end

  // ----------------------------------------------------------------------
  // Stream mode flag
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      stream_mode_reg <= 1'b0;
    end else if (win_write || win_read) begin
      stream_mode_reg <= 1'b1; // (R1)
    end else if (mode_byte0_access) begin
      stream_mode_reg <= 1'b0; // (R9)
    end
  end

  // ----------------------------------------------------------------------
  // Address generator
  // ----------------------------------------------------------------------
  // The host only ever names FIFO-loadable registers, so no filtering is done. (R7)
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= stream_unpack_pkg::ST_HEADER;
      slot_reg <= stream_unpack_pkg::SLOT_RESET;
      header_reg <= stream_unpack_pkg::HEADER_RESET;
    end else if (mode_byte0_access) begin
      state_reg <= stream_unpack_pkg::ST_HEADER; // (R15)
      slot_reg <= stream_unpack_pkg::SLOT_RESET; // (R9)
    end else if (header_take) begin
      header_reg <= win_wdata; // (R2)
      slot_reg <= stream_unpack_pkg::SLOT_RESET;
      state_reg <= stream_unpack_pkg::ST_DATA;
    end else if (data_take) begin
      slot_reg <= slot_reg + 2'h1;
      if (slot_reg == 2'(stream_unpack_pkg::SLOTS - 1)) begin
        state_reg <= stream_unpack_pkg::ST_HEADER; // (R8)
      end
    end
  end

  // ----------------------------------------------------------------------
  // Two-entry buffer and registered FIFO outputs
  // ----------------------------------------------------------------------
  // The buffer decouples the host from a stalled bus FIFO without losing words.
  skid_buffer2 #(
    .WIDTH(ENTRY_W)
  ) u_buf (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .flush(1'b0),
    .in_valid(data_take),
    .in_ready(buf_in_ready),
    .in_data({cur_start, cur_index, win_wdata}),
    .out_valid(buf_out_valid),
    .out_ready(out_free),
    .out_data(buf_out_data)
  );

  assign out_free = !fifo_v_reg || fifo_ready;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      fifo_v_reg <= 1'b0;
      fifo_entry_reg <= '0;
    end else if (out_free) begin
      fifo_v_reg <= buf_out_valid; // (R4)
      if (buf_out_valid) begin
        fifo_entry_reg <= buf_out_data;
      end
    end
  end

  assign fifo_valid = fifo_v_reg;
  assign fifo_data = fifo_entry_reg[DATA_W-1:0];
  assign fifo_index = fifo_entry_reg[DATA_W +: stream_unpack_pkg::INDEX_W];
  assign fifo_start = fifo_entry_reg[ENTRY_W-1]; // (R14)

  // ----------------------------------------------------------------------
  // Image load path
  // ----------------------------------------------------------------------
  // Dump data travels the read side of the window, outside this block.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pix_valid_reg <= 1'b0;
      pix_data_reg <= '0;
    end else if (pixel_take) begin
      pix_valid_reg <= 1'b1; // (R11)
      pix_data_reg <= win_wdata;
    end else if (pixel_ready) begin
      pix_valid_reg <= 1'b0;
    end
  end

  assign pixel_valid = pix_valid_reg;
  assign pixel_data = pix_data_reg;
  assign stream_mode = stream_mode_reg;
  assign header_pending = (state_reg == stream_unpack_pkg::ST_HEADER);

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  property p_header_latch;
    @(posedge ref_clk) disable iff (!nrst)
    header_take |=> (header_reg == $past(win_wdata)) && (state_reg == stream_unpack_pkg::ST_DATA);
  endproperty
  a_header_latch: assert property (p_header_latch) else $error("Header not latched."); // (R2)

  property p_lane_order;
    @(posedge ref_clk) disable iff (!nrst)
    (data_take && slot_reg == 2'h0) |-> cur_index == header_index_zero;
  endproperty
  a_lane_order: assert property (p_lane_order) else $error("Wrong header lane used."); // (R3)

  property p_last_lane;
    @(posedge ref_clk) disable iff (!nrst)
    (data_take && slot_reg == 2'h3) |-> cur_index == header_index_three;
  endproperty
  a_last_lane: assert property (p_last_lane) else $error("Fourth word used wrong lane."); // (R3)

  property p_regroup;
    @(posedge ref_clk) disable iff (!nrst)
    (data_take && slot_reg == 2'h3 && !mode_byte0_access) |=> header_pending;
  endproperty
  a_regroup: assert property (p_regroup) else $error("No new header after four words."); // (R8)

  property p_abort;
    @(posedge ref_clk) disable iff (!nrst)
    mode_byte0_access |=> header_pending && slot_reg == 2'h0;
  endproperty
  a_abort: assert property (p_abort) else $error("Mode access did not reset generator."); // (R15)

  property p_enter;
    @(posedge ref_clk) disable iff (!nrst)
    (win_write || win_read) |=> stream_mode;
  endproperty
  a_enter: assert property (p_enter) else $error("Stream mode not entered."); // (R1)

  property p_forward;
    @(posedge ref_clk) disable iff (!nrst)
    (data_take && !fifo_v_reg && !buf_out_valid) |-> ##2 (fifo_valid && fifo_data == $past(win_wdata, 2));
  endproperty
  a_forward: assert property (p_forward) else $error("Data word not forwarded."); // (R4)

  property p_hold;
    @(posedge ref_clk) disable iff (!nrst)
    (fifo_valid && !fifo_ready) |=> fifo_valid && $stable(fifo_data) && $stable(fifo_index);
  endproperty
  a_hold: assert property (p_hold) else $error("FIFO word dropped under stall."); // (R4)

  property p_start_range;
    @(posedge ref_clk) disable iff (!nrst)
    fifo_valid |-> fifo_start == (!fifo_index[7] && fifo_index[6:0] >= 7'h40);
  endproperty
  a_start_range: assert property (p_start_range) else $error("Start flag mismatches index."); // (R14)

  property p_pixel;
    @(posedge ref_clk) disable iff (!nrst)
    pixel_take |=> pixel_valid && pixel_data == $past(win_wdata);
  endproperty
  a_pixel: assert property (p_pixel) else $error("Image word not passed."); // (R11)

  property p_abort_drop;
    @(posedge ref_clk) disable iff (!nrst)
    (mode_byte0_access && win_write) |=> $stable(header_reg) && header_pending;
  endproperty
  a_abort_drop: assert property (p_abort_drop) else $error("Write beside mode access was taken."); // (R9)

  property p_slot_step;
    @(posedge ref_clk) disable iff (!nrst)
    (data_take && slot_reg != 2'h3) |=> !header_pending && slot_reg == $past(slot_reg) + 2'h1;
  endproperty
  a_slot_step: assert property (p_slot_step) else $error("Slot did not advance by one."); // (R3)

  property p_index_carried;
    @(posedge ref_clk) disable iff (!nrst)
    (data_take && !fifo_v_reg && !buf_out_valid) |->
      ##2 (fifo_index == $past(cur_index, 2) && fifo_start == $past(cur_start, 2));
  endproperty
  a_index_carried: assert property (p_index_carried) else $error("Index not forwarded with data."); // (R5)

  property p_mode_clear;
    @(posedge ref_clk) disable iff (!nrst)
    (mode_byte0_access && !win_write && !win_read) |=> !stream_mode;
  endproperty
  a_mode_clear: assert property (p_mode_clear) else $error("Mode access did not end stream mode."); // (R9)

  property p_pixel_hold;
    @(posedge ref_clk) disable iff (!nrst)
    (pixel_valid && !pixel_ready) |=> pixel_valid && $stable(pixel_data);
  endproperty
  a_pixel_hold: assert property (p_pixel_hold) else $error("Image word dropped under stall."); // (R11)

  property p_mode_stay;
    @(posedge ref_clk) disable iff (!nrst)
    (stream_mode && !mode_byte0_access) |=> stream_mode;
  endproperty
  a_mode_stay: assert property (p_mode_stay) else $error("Stream mode left without mode access."); // (R1)

  property p_no_spurious;
    @(posedge ref_clk) disable iff (!nrst)
    (!fifo_valid && !buf_out_valid) |=> !fifo_valid;
  endproperty
  a_no_spurious: assert property (p_no_spurious) else $error("FIFO word appeared from nowhere."); // (R4)

endmodule

/* File: bench/host_model.sv */
// Host model that writes double words into the stream window.
`timescale 1ns/1ns
module host_model (
  input wire logic ref_clk,
  input wire logic win_ready,
  output logic win_write,
  output logic [stream_unpack_pkg::DATA_W-1:0] win_wdata
);
  logic rdy;
  logic [stream_unpack_pkg::DATA_W-1:0] last;
  initial begin
    win_write = 1'b0;
    win_wdata = '0;
    last = '0;
  end
  // Called at a falling edge; the word is held whole until the edge that takes it.
  task automatic send(input logic [stream_unpack_pkg::DATA_W-1:0] w);
    win_write = 1'b1;
    win_wdata = w;
    last = w;
    rdy = 1'b0;
    while (!rdy) begin
      @(posedge ref_clk);
      rdy = (win_ready === 1'b1);
    end
    @(negedge ref_clk);
  endtask
  // A released bus shows no stale word, so the simulator cannot hide a late capture.
  task automatic idle();
    win_write = 1'b0;
    win_wdata = ~last;
    @(negedge ref_clk);
  endtask
endmodule

/* File: bench/register_stream_unpacker_tb.sv */
// Self-checking testbench for the register stream unpacker.
`timescale 1ns/1ns
module register_stream_unpacker_tb;
  logic ref_clk, nrst, win_write, win_read, win_ready, mode_byte0_access;
  logic image_op_active, image_load_op, pixel_valid, pixel_ready;
  logic fifo_valid, fifo_start, fifo_ready, stream_mode, header_pending;
  logic [31:0] win_wdata, pixel_data, fifo_data;
  logic [7:0] fifo_index;
  logic [40:0] exp_q[$];
  logic [31:0] pix_q[$];
  int err_total, n_checks, refused;

  register_stream_unpacker dut (.ref_clk(ref_clk), .nrst(nrst), .win_write(win_write),
    .win_read(win_read), .win_wdata(win_wdata), .win_ready(win_ready),
    .mode_byte0_access(mode_byte0_access), .image_op_active(image_op_active),
    .image_load_op(image_load_op), .image_dump_op(1'b0), .pixel_valid(pixel_valid),
    .pixel_data(pixel_data), .pixel_ready(pixel_ready), .fifo_valid(fifo_valid),
    .fifo_data(fifo_data), .fifo_index(fifo_index), .fifo_start(fifo_start),
    .fifo_ready(fifo_ready), .stream_mode(stream_mode), .header_pending(header_pending));
  host_model host (.ref_clk(ref_clk), .win_ready(win_ready), .win_write(win_write),
    .win_wdata(win_wdata));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic chk_word(input logic [40:0] got, input logic [40:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  always @(posedge ref_clk) begin
    if (win_write === 1'b1 && win_ready === 1'b0) refused++;
    if (fifo_valid === 1'b1 && fifo_ready === 1'b1) begin
      if (exp_q.size() == 0) chk_word({fifo_start, fifo_index, fifo_data}, 41'h1_5a5a_5a5a_5a);
      else chk_word({fifo_start, fifo_index, fifo_data}, exp_q.pop_front());
    end
    if (pixel_valid === 1'b1 && pixel_ready === 1'b1) begin
      if (pix_q.size() == 0) chk_word({9'h0, pixel_data}, 41'h1_5a5a_5a5a_5a);
      else chk_word({9'h0, pixel_data}, {9'h0, pix_q.pop_front()});
    end
  end

  // Start flag: index bit 7 clear keeps the first range, and bit 6 set lands in the launch block.
  function automatic logic [40:0] ent(input logic [7:0] ix, input logic [31:0] d);
    return {~ix[7] & ix[6], ix, d};
  endfunction

  task automatic grp(input logic [31:0] hdr, input logic [31:0] base, input int n);
    host.send(hdr);
    for (int k = 0; k < n; k++) begin
      exp_q.push_back(ent(hdr[8*k +: 8], base + k));
      host.send(base + k);
    end
  endtask

  task automatic drain();
    for (int i = 0; i < 300 && (exp_q.size() != 0 || pix_q.size() != 0); i++) @(negedge ref_clk);
    chk_bit(exp_q.size() == 0 && pix_q.size() == 0, 1'b1);
  endtask

  task automatic t_reset_enter();
    chk_bit(header_pending, 1'b1);
    chk_bit(stream_mode, 1'b0);
    chk_bit(fifo_valid, 1'b0);
    win_read = 1'b1;
    @(negedge ref_clk);
    win_read = 1'b0;
    chk_bit(stream_mode, 1'b1);
    mode_byte0_access = 1'b1;
    @(negedge ref_clk);
    mode_byte0_access = 1'b0;
    chk_bit(stream_mode, 1'b0);
  endtask

  task automatic t_groups();
    grp(32'hc0_80_3f_01, 32'h1000_0000, 4);
    grp(32'h40_7f_bf_ff, 32'h2000_0000, 4);
    host.idle();
    chk_bit(stream_mode, 1'b1);
    chk_bit(header_pending, 1'b1);
    drain();
  endtask

  task automatic t_stall();
    fifo_ready = 1'b0;
    refused = 0;
    fork
      grp(32'h44_c1_02_fe, 32'h3000_0000, 4);
      begin
        repeat (14) @(negedge ref_clk);
        fifo_ready = 1'b1;
      end
    join
    host.idle();
    chk_bit(refused > 0, 1'b1);
    drain();
  endtask

  task automatic t_abort();
    grp(32'h11_22_33_44, 32'h4000_0000, 2);
    fork
      host.send(32'h4000_00ff);
      begin
        mode_byte0_access = 1'b1;
        @(negedge ref_clk);
        mode_byte0_access = 1'b0;
      end
    join
    host.idle();
    chk_bit(header_pending, 1'b1);
    mode_byte0_access = 1'b1;
    @(negedge ref_clk);
    mode_byte0_access = 1'b0;
    chk_bit(header_pending, 1'b1);
    chk_bit(stream_mode, 1'b0);
    grp(32'hd0_05_90_0a, 32'h5000_0000, 4);
    host.idle();
    drain();
  endtask

  task automatic t_image();
    image_op_active = 1'b1;
    image_load_op = 1'b1;
    pixel_ready = 1'b0;
    fork
      for (int k = 0; k < 5; k++) begin
        pix_q.push_back(32'h6000_0000 + k);
        host.send(32'h6000_0000 + k);
      end
      begin
        repeat (10) @(negedge ref_clk);
        pixel_ready = 1'b1;
      end
    join
    host.idle();
    drain();
    image_op_active = 1'b0;
    image_load_op = 1'b0;
  endtask

  task automatic test_done();
    $display("Checks %0d, mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    #100000;
    err_total++;
    test_done();
  end

  initial begin
    err_total = 0;
    n_checks = 0;
    refused = 0;
    nrst = 1'b0;
    win_read = 1'b0;
    mode_byte0_access = 1'b0;
    image_op_active = 1'b0;
    image_load_op = 1'b0;
    pixel_ready = 1'b1;
    fifo_ready = 1'b1;
    repeat (16) @(negedge ref_clk);
    nrst = 1'b1;
    t_reset_enter();
    t_groups();
    t_stall();
    t_abort();
    t_image();
    test_done();
  end
endmodule
